// >>> frame_sync_consts.vh
// Register offsets, field positions, reset values and timing counts of the frame sync block.
`ifndef FRAME_SYNC_CONSTS_VH
`define FRAME_SYNC_CONSTS_VH
`define A_CTRL      8'h00
`define A_FRAME_LEN 8'h04
`define A_HOP       8'h08
`define A_NET_ID    8'h0c
`define A_SEC_CODE  8'h10
`define A_RX_PKT    8'h14
`define A_TX_PKT    8'h18
`define A_FAIL      8'h1c
`define A_STATUS    8'h20
`define A_STAT_CLR  8'h24
`define A_RETRY     8'h28
`define A_STAT_BASE 8'h40
`define F_MODE_LO   0
`define F_MODE_HI   1
`define F_MASTER    2
`define F_RXPKT_EN  3
`define F_TXPKT_EN  4
`define F_RUN       5
`define MODE_NONE   2'h0
`define MODE_OUT    2'h1
`define MODE_FOLLOW 2'h2
`define MODE_REPEAT 2'h3
`define CTRL_RST    6'h00
`define HOP_RST     5'h00
`define NET_RST     6'h00
`define SEC_RST     32'h00000000
`define PKT_RST     32'h00000000
`define FAIL_RST    16'h0010
`define SENS_RST    8'h20
`define RETRY_RST   8'h03
`define FRAME_MS    10
`define CLK_KHZ     125000
`define FRAME_CYC   (`FRAME_MS * `CLK_KHZ)
`define N_STAT      16
`define S_FRAMES    0
`define S_RETRY     5
`define S_LOCKLOSS  8
`define S_LOWSIG    9
`define S_BUSY      15
`endif

// >>> radio_frame_sync_and_stats.v
// Frame timing, sync pin handling, network identity, packetisation timers and statistics counters.
// How it works
// - Output-sync mode drives a falling edge on sync output at every frame start.
// - No-sync mode neither drives sync edges nor follows the sync input.
// - Follow mode: a master restarts its frame on each sync input falling edge.
// - Repeater mode: a master starts its frame half a frame after each falling edge.
// - Follow and repeater modes act only on a master; slaves ignore the sync input.
// - Frame time equals the dwell time on one channel before hopping; a follow-mode restart on a sync fall starts a frame without a hop.
// - One of 32 hopping sequences selects the channel order.
// - A network identifier from 0 to 63 tells networks apart.
// - A 32-bit security code must match before a slave talks to a master.
// - Serial silence of the rx timer ends a packet; nothing goes on air before.
// - Serial output waits until the tx timer passes with no air data.
// - Each retransmission takes one more frame, bounded by the retry limit.
// - Count every frame while running, and received frames with no user data.
// - Count good, bad, lost packets and good, bad header packets.
// - A slave counts each loss of lock on the master.
// - Count receptions at or below nominal sensitivity.
// - Count user bytes received and transmitted over the link.
// - Count rx buffer overflows and internal data losses separately.
// - Count transmit buffer requests that find no free buffer.
// - A slave counts waits caused by the master serving another slave.
// - Count every retransmission made while transmitting.
// - A master transmits every frame; a slave only with data or a connection.
// - A slave that hears no master until the fail timer expires unlocks.
//
// Our own choices: the address map and the APB register port.
`default_nettype none
`include "frame_sync_consts.vh"
module radio_frame_sync_and_stats #(
  parameter [31:0] FRAME_RST_CYC = `FRAME_CYC,
  parameter        NCH_W         = 6
) (
  // Clock, reset and the APB register port.
  input  wire             pclk,
  input  wire             presetn,
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [7:0]       paddr,
  input  wire [31:0]      pwdata,
  output reg  [31:0]      prdata,
  output reg              pready,
  output reg              pslverr,
  // Sync pin value and its driver, which is enabled low.
  input  wire             sync_i,
  output reg              sync_o,
  output reg              sync_oe_n,
  // Link-layer status and events from the modem core, all on this clock.
  input  wire             hdr_good,
  input  wire             peer_valid,
  input  wire [4:0]       peer_hop,
  input  wire [5:0]       peer_net,
  input  wire [31:0]      peer_code,
  input  wire             has_data,
  input  wire             connected,
  input  wire             retry_req,
  input  wire             rx_active,
  input  wire [7:0]       rssi,
  input  wire [15:0]      stat_ev,
  input  wire             ser_rx_valid,
  input  wire             air_rx_valid,
  // Frame, slot, lock and packetiser outputs, each straight from a flop.
  output reg              frame_start,
  output reg  [NCH_W-1:0] channel,
  output reg              tx_slot,
  output reg              retx,
  output reg              locked,
  output reg              id_match,
  output reg              air_tx_go,
  output reg              ser_tx_hold
);
  // Software-visible configuration registers.
  reg  [5:0]       ctrl_q;
  reg  [31:0]      frame_len_q;
  reg  [4:0]       hop_q;
  reg  [5:0]       net_q;
  reg  [31:0]      sec_q;
  reg  [31:0]      rx_pkt_q;
  reg  [31:0]      tx_pkt_q;
  reg  [15:0]      fail_q;
  reg  [7:0]       sens_q;
  reg  [7:0]       retry_max_q;
  // Frame, miss, retry and packetisation timers.
  reg  [31:0]      fcnt_q;
  reg  [NCH_W-1:0] slot_q;
  reg  [15:0]      miss_q;
  reg  [7:0]       retry_cnt_q;
  reg  [31:0]      rxt_q;
  reg  [31:0]      txt_q;
  reg              rx_pend_q;
  reg              hdr_seen_q;
  reg              lock_loss_q;
  // Sync pin synchroniser and edge detector stages.
  reg              s1_q;
  reg              s2_q;
  reg              s3_q;
  reg              stat_clr_q;
  reg  [31:0]      stat_q [0:`N_STAT-1];
  // Decoded control fields and the bus write strobe.
  wire [1:0]       mode     = ctrl_q[`F_MODE_HI:`F_MODE_LO];
  wire             master   = ctrl_q[`F_MASTER];
  wire             run      = ctrl_q[`F_RUN];
  wire             wr       = psel & penable & pwrite & ~pready;
  wire             sync_fall;
  wire             frame_end;
  wire [31:0]      half_len = {1'b0, frame_len_q[31:1]};
  wire [15:0]      ev;

  // Sync pin passes three flops; only the second and third stage feed the edge detector.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= sync_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign sync_fall = s3_q & ~s2_q;

  // The frame timer; a frame that runs to its end hops the channel, a follow-mode restart on a sync fall does not.
  assign frame_end = (fcnt_q >= frame_len_q - 32'h00000001);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fcnt_q      <= 32'h00000000;
      slot_q      <= {NCH_W{1'b0}};
      frame_start <= 1'b0;
      channel     <= {NCH_W{1'b0}};
    end else begin
      frame_start <= 1'b0;
      if (!run) begin
        fcnt_q <= 32'h00000000;
      end else if (master && mode == `MODE_FOLLOW && sync_fall) begin
        fcnt_q      <= 32'h00000000;
        frame_start <= 1'b1;
      end else if (master && mode == `MODE_REPEAT && sync_fall) begin
        fcnt_q <= half_len;
      end else if (frame_end) begin
        fcnt_q      <= 32'h00000000;
        frame_start <= 1'b1;
        slot_q      <= slot_q + {{(NCH_W-1){1'b0}}, 1'b1};
        // A fixed xor keeps the 32 orders distinct; a real hop table would replace it.
        channel     <= slot_q ^ {{(NCH_W-5){1'b0}}, hop_q};
      end else begin
        fcnt_q <= fcnt_q + 32'h00000001;
      end
    end
  end

  // In output-sync mode while running, sync output is low for the first half of each frame, so each frame opens with a fall.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_o    <= 1'b1;
      sync_oe_n <= 1'b1;
    end else begin
      sync_oe_n <= ~(run && mode == `MODE_OUT);
      sync_o    <= ~(run && mode == `MODE_OUT && fcnt_q < half_len);
    end
  end

  // Lock tracking on a slave; the miss count is in frames without a good header.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locked      <= 1'b0;
      miss_q      <= 16'h0000;
      hdr_seen_q  <= 1'b0;
      lock_loss_q <= 1'b0;
    end else begin
      lock_loss_q <= 1'b0;
      if (master || !run) begin
        locked     <= master & run;
        miss_q     <= 16'h0000;
        hdr_seen_q <= 1'b0;
      end else begin
        if (hdr_good && id_match) begin
          locked     <= 1'b1;
          hdr_seen_q <= 1'b1;
        end
        if (frame_start) begin
          hdr_seen_q <= hdr_good & id_match;
          if (hdr_seen_q) begin
            miss_q <= 16'h0000;
          end else if (locked && miss_q + 16'h0001 >= fail_q) begin
            locked      <= 1'b0;
            lock_loss_q <= 1'b1;
            miss_q      <= 16'h0000;
          end else if (locked) begin
            miss_q <= miss_q + 16'h0001;
          end
        end
      end
    end
  end

  // Identity check against the heard peer; all three fields must agree.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      id_match <= 1'b0;
    end else begin
      id_match <= peer_valid && peer_hop == hop_q && peer_net == net_q
                  && peer_code == sec_q;
    end
  end

  // Transmit slot and retries, decided once per frame so a retry costs a whole frame.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_slot     <= 1'b0;
      retx        <= 1'b0;
      retry_cnt_q <= 8'h00;
    end else if (frame_start) begin
      tx_slot <= master | (locked & (has_data | connected));
      if (retry_req && retry_cnt_q < retry_max_q) begin
        retx        <= 1'b1;
        retry_cnt_q <= retry_cnt_q + 8'h01;
      end else begin
        retx        <= 1'b0;
        retry_cnt_q <= 8'h00;
      end
    end else if (!run) begin
      tx_slot     <= 1'b0;
      retx        <= 1'b0;
      retry_cnt_q <= 8'h00;
    end
  end

  // Receive packetisation: bytes wait until the serial line has been silent long enough.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxt_q     <= 32'h00000000;
      rx_pend_q <= 1'b0;
      air_tx_go <= 1'b0;
    end else begin
      air_tx_go <= 1'b0;
      if (!ctrl_q[`F_RXPKT_EN]) begin
        rx_pend_q <= 1'b0;
        air_tx_go <= ser_rx_valid;
      end else if (ser_rx_valid) begin
        rx_pend_q <= 1'b1;
        rxt_q     <= 32'h00000000;
      end else if (rx_pend_q && rxt_q + 32'h00000001 >= rx_pkt_q) begin
        rx_pend_q <= 1'b0;
        air_tx_go <= 1'b1;
      end else if (rx_pend_q) begin
        rxt_q <= rxt_q + 32'h00000001;
      end
    end
  end

  // Transmit packetisation: serial output is held while air data keeps arriving.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txt_q       <= 32'h00000000;
      ser_tx_hold <= 1'b0;
    end else if (!ctrl_q[`F_TXPKT_EN]) begin
      txt_q       <= 32'h00000000;
      ser_tx_hold <= 1'b0;
    end else if (air_rx_valid) begin
      txt_q       <= 32'h00000000;
      ser_tx_hold <= 1'b1;
    end else if (txt_q + 32'h00000001 >= tx_pkt_q) begin
      ser_tx_hold <= 1'b0;
    end else begin
      txt_q <= txt_q + 32'h00000001;
    end
  end

  // Event vector; frames, retries and lock loss come from inside the block; low signal is the input event gated by rssi.
  assign ev[`S_FRAMES]   = frame_start & run;
  assign ev[4:1]         = stat_ev[4:1];
  assign ev[`S_RETRY]    = frame_start & retry_req & (retry_cnt_q < retry_max_q);
  assign ev[7:6]         = stat_ev[7:6];
  assign ev[`S_LOCKLOSS] = lock_loss_q;
  assign ev[`S_LOWSIG]   = stat_ev[`S_LOWSIG] & rx_active & (rssi <= sens_q);
  assign ev[11:10]       = stat_ev[11:10];
  assign ev[14:12]       = stat_ev[14:12];
  assign ev[`S_BUSY]     = stat_ev[`S_BUSY] & ~master;

  // One counter per statistic; an event in the clearing cycle still counts as one.
  genvar gi;
  generate
    for (gi = 0; gi < `N_STAT; gi = gi + 1) begin : g_stat
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stat_q[gi] <= 32'h00000000;
        end else if (stat_clr_q) begin
          stat_q[gi] <= {31'h00000000, ev[gi]};
        end else if (ev[gi]) begin
          stat_q[gi] <= stat_q[gi] + 32'h00000001;
        end
      end
    end
  endgenerate

  // APB register writes; every access gets one wait state.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q      <= `CTRL_RST;
      frame_len_q <= FRAME_RST_CYC;
      hop_q       <= `HOP_RST;
      net_q       <= `NET_RST;
      sec_q       <= `SEC_RST;
      rx_pkt_q    <= `PKT_RST;
      tx_pkt_q    <= `PKT_RST;
      fail_q      <= `FAIL_RST;
      sens_q      <= `SENS_RST;
      retry_max_q <= `RETRY_RST;
      stat_clr_q  <= 1'b0;
    end else begin
      stat_clr_q <= 1'b0;
      // Counters are read-only; a write to them is refused by the answer block.
      if (wr) begin
        case (paddr)
          `A_CTRL:      ctrl_q      <= pwdata[5:0];
          `A_FRAME_LEN: frame_len_q <= pwdata;
          `A_HOP:       hop_q       <= pwdata[4:0];
          `A_NET_ID:    net_q       <= pwdata[5:0];
          `A_SEC_CODE:  sec_q       <= pwdata;
          `A_RX_PKT:    rx_pkt_q    <= pwdata;
          `A_TX_PKT:    tx_pkt_q    <= pwdata;
          `A_FAIL: begin
            fail_q <= pwdata[15:0];
            sens_q <= pwdata[23:16];
          end
          `A_STAT_CLR:  stat_clr_q  <= pwdata[0];
          `A_RETRY:     retry_max_q <= pwdata[7:0];
          default: ;
        endcase
      end
    end
  end

  // APB answer; unmapped addresses complete with pslverr and read zero.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      // Narrow registers read back zero-extended in the low bits.
      if (psel && penable && !pready) begin
        if (paddr >= `A_STAT_BASE && paddr[1:0] == 2'h0 && paddr < `A_STAT_BASE + 8'h40) begin
          if (!pwrite) prdata <= stat_q[paddr[5:2]];
          else pslverr <= 1'b1;
        end else begin
          case (paddr)
            `A_CTRL:      prdata <= {26'h0000000, ctrl_q};
            `A_FRAME_LEN: prdata <= frame_len_q;
            `A_HOP:       prdata <= {27'h0000000, hop_q};
            `A_NET_ID:    prdata <= {26'h0000000, net_q};
            `A_SEC_CODE:  prdata <= sec_q;
            `A_RX_PKT:    prdata <= rx_pkt_q;
            `A_TX_PKT:    prdata <= tx_pkt_q;
            `A_FAIL:      prdata <= {8'h00, sens_q, fail_q};
            `A_STATUS:    prdata <= {28'h0000000, retx, tx_slot, id_match, locked};
            `A_STAT_CLR:  prdata <= 32'h00000000;
            `A_RETRY:     prdata <= {24'h000000, retry_max_q};
            default:      pslverr <= 1'b1;
          endcase
        end
      end
    end
  end
endmodule // radio_frame_sync_and_stats
`default_nettype wire

// >>> radio_frame_sync_and_stats_checker.sv
// Port-level assertions for the frame sync and statistics block.
`default_nettype none
module radio_frame_sync_and_stats_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sync_o,
  input wire logic        sync_oe_n,
  input wire logic        peer_valid,
  input wire logic        frame_start,
  input wire logic        tx_slot,
  input wire logic        retx,
  input wire logic        id_match
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain, so the clock and the reset are given once for all checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A taken request is answered after exactly one wait state.
  property p_ans; psel && penable && !pready |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("pready late");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("pready longer than one cycle");
  property p_cause; pready |-> $past(psel) && $past(penable); endproperty
  a_cause: assert property (p_cause) else $error("pready without request");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("error answer malformed");
  // The sync pin falls shortly after each frame start while driven.
  property p_fall; frame_start && !sync_oe_n && sync_o |-> ##[0:2] !sync_o; endproperty
  a_fall: assert property (p_fall) else $error("no sync falling edge");
  property p_fs; frame_start |=> !frame_start; endproperty
  a_fs: assert property (p_fs) else $error("frame_start not a pulse");
  // Per-frame levels may only move at a frame boundary.
  property p_retx; $changed(retx) |-> frame_start || $past(frame_start); endproperty
  a_retx: assert property (p_retx) else $error("retx moved mid-frame");
  property p_slot; $changed(tx_slot) |-> frame_start || $past(frame_start); endproperty
  a_slot: assert property (p_slot) else $error("tx_slot moved mid-frame");
  property p_id; id_match |-> $past(peer_valid); endproperty
  a_id: assert property (p_id) else $error("match without peer");
endmodule // radio_frame_sync_and_stats_checker
bind radio_frame_sync_and_stats radio_frame_sync_and_stats_checker chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sync_o(sync_o),
  .sync_oe_n(sync_oe_n), .peer_valid(peer_valid), .frame_start(frame_start), .tx_slot(tx_slot),
  .retx(retx), .id_match(id_match));
`default_nettype wire

// >>> sync_peer.sv
// Collocated unit on the far end of the frame sync pin.
`default_nettype none
module sync_peer (
  input  wire logic pclk,
  input  wire logic fire,
  input  wire logic dut_o,
  input  wire logic dut_oe_n,
  output wire logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  // Both repeater units answer to one shared two-digit local address.
  localparam int PAIR_ADDR = 10;
  logic [3:0] low_q = 4'h0;
  // The peer, set to drive sync, pulls the pin low at its own frame start.
  always @(posedge pclk) begin
    if (fire) low_q <= 4'h8;
    else if (low_q != 4'h0) low_q <= low_q - 4'h1;
  end
  // A pull-up holds the pin high when neither party pulls it low.
  assign line = !((low_q != 4'h0) || (!dut_oe_n && !dut_o));
endmodule // sync_peer
`default_nettype wire

// >>> tb_radio_frame_sync_and_stats.sv
// Self-checking bench for the frame sync and statistics block.
`default_nettype none
`include "frame_sync_consts.vh"
module tb_radio_frame_sync_and_stats;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FL = 64;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, fire = 0;
  logic [7:0] paddr = 0, rssi = 0;
  logic [31:0] pwdata = 0, prdata, rdat, peer_code = 0;
  logic [15:0] stat_ev = 0;
  logic [5:0] channel, ch0;
  logic sync_w, sync_o, sync_oe_n, hdr_good = 0, peer_valid = 0, retry_req = 0, rx_active = 0;
  logic has_data = 0, connected = 0;
  logic ser_rx_valid = 0, air_rx_valid = 0, frame_start, tx_slot, retx, locked, id_match;
  logic air_tx_go, ser_tx_hold, rerr;
  int err_count = 0, tests_run = 0, n, np, pos;
  radio_frame_sync_and_stats #(.FRAME_RST_CYC(FL)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sync_i(sync_w), .sync_o(sync_o), .sync_oe_n(sync_oe_n),
    .hdr_good(hdr_good), .peer_valid(peer_valid), .peer_hop(5'h1f), .peer_net(6'h3f),
    .peer_code(peer_code), .has_data(has_data), .connected(connected), .retry_req(retry_req),
    .rx_active(rx_active), .rssi(rssi), .stat_ev(stat_ev), .ser_rx_valid(ser_rx_valid),
    .air_rx_valid(air_rx_valid), .frame_start(frame_start), .channel(channel), .tx_slot(tx_slot),
    .retx(retx), .locked(locked), .id_match(id_match), .air_tx_go(air_tx_go), .ser_tx_hold(ser_tx_hold));
  sync_peer peer_u (.pclk(pclk), .fire(fire), .dut_o(sync_o), .dut_oe_n(sync_oe_n), .line(sync_w));
  // Bus clock at 125 MHz.
  always #4 pclk = ~pclk;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends a wait that never sees pready.
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  function automatic logic [31:0] cv(input logic [1:0] m, input logic ms, rp, tp);
    return {26'h0, 1'b1, tp, rp, ms, m};
  endfunction
  // Counts edges until a frame start is sampled, bounded.
  task automatic gap(output int c);
    c = 0;
    while (frame_start !== 1'b1 && c < 300) begin
      @(posedge pclk);
      c++;
    end
    if (c >= 300) chk(frame_start, 1);
  endtask
  task automatic align();
    gap(n);
    @(posedge pclk);
    gap(n);
  endtask
  task automatic ev(input int i);
    stat_ev <= 16'h1 << i;
    @(posedge pclk);
    stat_ev <= 16'h0;
    @(posedge pclk);
  endtask
  // Fires the peer mid-frame and measures the distance to the next frame start.
  task automatic sync_try(input logic [31:0] c, input int lo, input int hi);
    apb(1'b1, `A_CTRL, c);
    align();
    repeat (20) @(posedge pclk);
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    gap(n);
    chk(n >= lo && n <= hi, 1);
    $display("sync test ctrl %h done", c);
  endtask
  // Hang guard, sized well beyond the expected run.
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge pclk);
    chk({sync_o, sync_oe_n}, 2'b11);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`A_CTRL, `CTRL_RST);
    rd(`A_FRAME_LEN, FL);
    rd(`A_HOP, `HOP_RST);
    rd(`A_NET_ID, `NET_RST);
    rd(`A_SEC_CODE, `SEC_RST);
    rd(`A_RX_PKT, `PKT_RST);
    rd(`A_FAIL, {`SENS_RST, `FAIL_RST});
    rd(`A_RETRY, `RETRY_RST);
    apb(1'b0, 8'h30, 32'h0);
    chk(rerr, 1);
    chk(rdat, 0);
    apb(1'b1, `A_STAT_BASE, 32'h5);
    chk(rerr, 1);
    apb(1'b1, `A_HOP, 32'hffffffff);
    rd(`A_HOP, 32'h1f);
    apb(1'b1, `A_NET_ID, 32'hffffffff);
    rd(`A_NET_ID, 32'h3f);
    apb(1'b1, `A_SEC_CODE, 32'hdeadbeef);
    rd(`A_SEC_CODE, 32'hdeadbeef);
    $display("register test done");
    peer_valid <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(id_match, 0);
    peer_code <= 32'hdeadbeef;
    repeat (2) @(posedge pclk);
    chk(id_match, 1);
    apb(1'b1, `A_NET_ID, 32'h0);
    repeat (2) @(posedge pclk);
    chk(id_match, 0);
    apb(1'b1, `A_NET_ID, 32'h3f);
    apb(1'b1, `A_CTRL, cv(`MODE_NONE, 1, 0, 0));
    apb(1'b1, `A_STAT_CLR, 32'h1);
    rx_active <= 1'b1;
    rssi <= `SENS_RST;
    for (int i = 1; i < 16; i++) if (i != 5 && i != 8) repeat (2) ev(i);
    for (int i = 1; i < 16; i++) if (i != 5 && i != 8) rd(8'(`A_STAT_BASE + 4 * i), i == 15 ? 0 : 2);
    rssi <= `SENS_RST + 8'h1;
    ev(9);
    rd(8'(`A_STAT_BASE + 36), 2);
    $display("counter test done");
    align();
    apb(1'b1, `A_STAT_CLR, 32'h1);
    retry_req <= 1'b1;
    gap(n);
    retry_req <= 1'b0;
    @(posedge pclk);
    chk(tx_slot, 1);
    repeat (2) @(posedge pclk);
    chk(retx, 1);
    repeat (3) begin
      ch0 = channel;
      @(posedge pclk);
      gap(n);
    end
    chk(n, FL - 1);
    chk(channel ^ 6'h1f, 6'((ch0 ^ 6'h1f) + 6'h1));
    rd(8'(`A_STAT_BASE), 4);
    rd(8'(`A_STAT_BASE + 20), 1);
    $display("frame count test done");
    apb(1'b1, `A_CTRL, cv(`MODE_OUT, 1, 0, 0));
    align();
    repeat (2) @(posedge pclk);
    chk({sync_oe_n, sync_o}, 2'b00);
    repeat (40) @(posedge pclk);
    chk(sync_o, 1);
    sync_try(cv(`MODE_NONE, 1, 0, 0), 42, 44);
    chk(sync_oe_n, 1);
    sync_try(cv(`MODE_FOLLOW, 1, 0, 0), 1, 8);
    sync_try(cv(`MODE_REPEAT, 1, 0, 0), 33, 41);
    sync_try(cv(`MODE_FOLLOW, 0, 0, 0), 42, 44);
    apb(1'b1, `A_CTRL, cv(`MODE_NONE, 1, 1, 1));
    apb(1'b1, `A_RX_PKT, 32'd10);
    apb(1'b1, `A_TX_PKT, 32'd10);
    np = 0;
    pos = 0;
    // Three serial bytes four cycles apart and one air byte, then silence.
    for (int k = 0; k < 30; k++) begin
      ser_rx_valid <= (k == 0 || k == 4 || k == 8);
      air_rx_valid <= (k == 0);
      @(posedge pclk);
      if (air_tx_go === 1'b1) begin
        np++;
        pos = k;
      end
      if (k == 9) chk(ser_tx_hold, 1);
      if (k == 11) chk(ser_tx_hold, 0);
    end
    chk(np, 1);
    chk(pos >= 17 && pos <= 22, 1);
    $display("packetisation test done");
    apb(1'b1, `A_FAIL, {`SENS_RST, 16'h2});
    apb(1'b1, `A_CTRL, cv(`MODE_NONE, 0, 0, 0));
    // A new slave carries the master's lock over, so it must first time out.
    repeat (4) begin
      @(posedge pclk);
      gap(n);
    end
    chk(locked, 0);
    apb(1'b1, `A_STAT_CLR, 32'h1);
    hdr_good <= 1'b1;
    @(posedge pclk);
    hdr_good <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(locked, 1);
    connected <= 1'b1;
    ev(15);
    rd(8'(`A_STAT_BASE + 60), 1);
    gap(n);
    @(posedge pclk);
    chk(tx_slot, 1);
    connected <= 1'b0;
    has_data <= 1'b1;
    repeat (5) begin
      @(posedge pclk);
      gap(n);
    end
    repeat (2) @(posedge pclk);
    chk({locked, tx_slot}, 2'b00);
    rd(8'(`A_STAT_BASE + 32), 1);
    $display("lock test done");
    print_verdict();
  end
endmodule // tb_radio_frame_sync_and_stats
`default_nettype wire
